// ==== rtl/ppm_defs.vh ====
`ifndef PPM_DEFS_VH
`define PPM_DEFS_VH
// ---------------------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------------------
`define PPM_OFF_DIR      8'h00
`define PPM_OFF_OUT      8'h04
`define PPM_OFF_PIN      8'h08
`define PPM_OFF_CTRL     8'h0C
`define PPM_OFF_ALT      8'h10
`define PPM_OFF_ISTAT    8'h14
`define PPM_OFF_IMASK    8'h18
// ---------------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------------
`define PPM_CTRL_PUD     0
`define PPM_CTRL_SLEEP   1
`define PPM_CTRL_EXTEN   2
`define PPM_ALT_SPE      0
`define PPM_ALT_MSTR     1
`define PPM_ALT_PCIE     2
`define PPM_IST_EXTFLAG  0
`define PPM_IST_PCHG     1
// ---------------------------------------------------------------------------
// reset values, response codes and external interrupt pin
// ---------------------------------------------------------------------------
`define PPM_RST_BYTE     8'h00
`define PPM_RST_CTRL     3'h0
`define PPM_RESP_OKAY    2'b00
`define PPM_RESP_SLVERR  2'b10
`define PPM_EXT_PIN      3'd1
`endif

// ==== rtl/ppm_pin_cell.v ====
`timescale 1ns/10ps
`default_nettype none
// one pin: override mux, input enable, clamp
module ppm_pin_cell
(
  input  wire rstn,
  input  wire pinDirectionBit,
  input  wire pinOutputBit,
  input  wire globalPullupDisable,
  input  wire sleepClamp,
  input  wire pullupOverrideEn,
  input  wire pullupOverrideVal,
  input  wire dirOverrideEn,
  input  wire dirOverrideVal,
  input  wire valueOverrideEn,
  input  wire valueOverrideVal,
  input  wire inputEnOverrideEn,
  input  wire inputEnOverrideVal,
  input  wire extIntEn,
  input  wire padIn,
  output wire padOut,
  output wire padOe,
  output wire pullupOn,
  output wire altDigitalInput
);
  wire drvEn;
  wire inEn;
  assign drvEn = dirOverrideEn ? dirOverrideVal : pinDirectionBit;
  // reset forces tri-state without a clock
  assign padOe = rstn & drvEn;
  assign padOut = valueOverrideEn ? valueOverrideVal : pinOutputBit;
  assign pullupOn = rstn & (pullupOverrideEn ? pullupOverrideVal :
    ({pinDirectionBit, pinOutputBit, globalPullupDisable} == 3'b010));
  assign inEn = inputEnOverrideEn ? inputEnOverrideVal :
    (~sleepClamp | extIntEn);
  // clamp ahead of the trigger, taken before the port synchroniser
  assign altDigitalInput = padIn & inEn;
endmodule
`default_nettype wire

// ==== rtl/ppm_pin_sync.v ====
`timescale 1ns/10ps
`default_nettype none
// three-stage input sync, change accepted when stages two and three agree
module ppm_pin_sync
(
  input  wire sys_clk,
  input  wire rstn,
  input  wire din,
  output reg  dout
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        dout <= s3_r;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/ppm_port_mux.v ====
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------------------
// Summary of operation
// - clamp digital inputs in deep sleep modes
// - enabled external interrupt pins escape clamp
// - clamp edge sets interrupt flag on wake
// - pull-ups off during reset
// - pull-up override else 010 pattern
// - direction override drives output enable
// - value override selects driven level
// - toggle override inverts output bit
// - input enable override beats sleep state
// - alt input after trigger, before sync
// - strobes per port, clamp/pud global
// - overrides come from owning peripherals
// - port b alternate function map
// - direction one drives, zero inputs/pull-up
// - writing input bit toggles output bit
// - tri-state immediately on reset
// - latch then register on input read
// ---------------------------------------------------------------------------
`include "ppm_defs.vh"
module ppm_port_mux
(
  input  wire        sys_clk,
  input  wire        rstn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [7:0]  padIn,
  output wire [7:0]  padOut,
  output wire [7:0]  padOe,
  output wire [7:0]  pullupOn,
  input  wire        timer2CompareAOut,
  input  wire        timer2CompareAEn,
  input  wire        timer1CompareBOut,
  input  wire        timer1CompareBEn,
  input  wire        timer1CompareAOut,
  input  wire        timer1CompareAEn,
  input  wire        timer0CompareAOut,
  input  wire        timer0CompareAEn,
  input  wire        spiSlaveOut,
  input  wire        spiMasterOut,
  input  wire        spiSckOut,
  input  wire [7:0]  toggleOverrideEn,
  output wire [7:0]  altDigitalInput,
  output wire [7:0]  pinChangeSrc,
  output wire        spiMasterIn,
  output wire        spiSlaveIn,
  output wire        spiSckIn,
  output wire        spiSelectIn,
  output wire        irq
);
  reg  [7:0]  dir_r;
  reg  [7:0]  out_r;
  reg  [7:0]  out_nxt;
  reg  [2:0]  ctrl_r;
  reg  [2:0]  alt_r;
  reg  [1:0]  istat_r;
  reg  [1:0]  imask_r;
  reg  [7:0]  latch_r;
  reg  [7:0]  pin_r;
  reg  [7:0]  altPrev_r;
  reg         extPend_r;
  reg         sleepPrev_r;
  reg         awHeld_r;
  reg         wHeld_r;
  reg  [7:0]  awAddr_r;
  reg  [31:0] wData_r;
  reg  [3:0]  wStrb_r;
  wire [7:0]  syncIn;
  wire [7:0]  inSync;
  wire        gPud;
  wire        sleepClamp;
  wire        extEn;
  wire        spiMaster;
  wire [7:0]  pullup_override_en;
  wire [7:0]  pullup_override_val;
  wire [7:0]  dir_override_en;
  wire [7:0]  value_override_en;
  wire [7:0]  value_override_val;
  wire [7:0]  input_en_override_en;
  wire [7:0]  extEnVec;
  wire        doWrite;
  wire        wrHit;
  wire [7:0]  wByte;
  wire        pinToggleWr;
  wire [1:0]  evSet;
  wire        extWake;
  genvar      gi;

  // global controls shared by every port
  assign gPud       = ctrl_r[`PPM_CTRL_PUD];
  assign sleepClamp = ctrl_r[`PPM_CTRL_SLEEP];
  assign extEn      = ctrl_r[`PPM_CTRL_EXTEN];
  assign spiMaster  = alt_r[`PPM_ALT_SPE] & alt_r[`PPM_ALT_MSTR];

  // ---------------------------------------------------------------------------
  // per-pin override terms, as the owning peripherals present them
  // ---------------------------------------------------------------------------
  assign pullup_override_en  = {4'h0, {4{spiMaster}}};
  assign pullup_override_val  = {4'h0, out_r[3:0] & {4{gPud}}};
  assign dir_override_en  = {4'h0, {4{spiMaster}}};
  assign value_override_en  = {timer2CompareAEn, timer1CompareBEn, timer1CompareAEn,
                  timer0CompareAEn, {3{spiMaster}}, 1'b0};
  assign value_override_val  = {timer2CompareAOut, timer1CompareBOut, timer1CompareAOut,
                  timer0CompareAOut, spiSlaveOut, spiMasterOut, spiSckOut,
                  1'b0};
  assign input_en_override_en = {8{alt_r[`PPM_ALT_PCIE]}};
  assign extEnVec = {8{extEn}} & (8'h01 << `PPM_EXT_PIN);

  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_pin
      ppm_pin_cell u_cell
      (
        .rstn               (rstn),
        .pinDirectionBit    (dir_r[gi]),
        .pinOutputBit       (out_r[gi]),
        .globalPullupDisable(gPud),
        .sleepClamp         (sleepClamp),
        .pullupOverrideEn   (pullup_override_en[gi]),
        .pullupOverrideVal  (pullup_override_val[gi]),
        .dirOverrideEn      (dir_override_en[gi]),
        .dirOverrideVal     (1'b0),
        .valueOverrideEn    (value_override_en[gi]),
        .valueOverrideVal   (value_override_val[gi]),
        .inputEnOverrideEn  (input_en_override_en[gi]),
        .inputEnOverrideVal (1'b1),
        .extIntEn           (extEnVec[gi]),
        .padIn              (padIn[gi]),
        .padOut             (padOut[gi]),
        .padOe              (padOe[gi]),
        .pullupOn           (pullupOn[gi]),
        .altDigitalInput    (syncIn[gi])
      );
      // events only: readable bits and peripherals keep the raw path
      ppm_pin_sync u_sync
      (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .din     (syncIn[gi]),
        .dout    (inSync[gi])
      );
    end
  endgenerate

  // raw, unsynchronised: receivers sync themselves unless used as clock
  assign altDigitalInput = syncIn;
  assign pinChangeSrc    = syncIn;
  assign spiMasterIn     = syncIn[3];
  assign spiSlaveIn      = syncIn[2];
  assign spiSckIn        = syncIn[1];
  assign spiSelectIn     = syncIn[0];

  // ---------------------------------------------------------------------------
  // readable pin bits: negative-edge capture stands in for the clock-high latch
  // ---------------------------------------------------------------------------
  always @(negedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      latch_r <= `PPM_RST_BYTE;
    else
      latch_r <= syncIn;
  end

  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      pin_r <= `PPM_RST_BYTE;
    else
      pin_r <= latch_r;
  end

  // ---------------------------------------------------------------------------
  // axi4-lite write path
  // ---------------------------------------------------------------------------
  assign s_axi_awready = ~awHeld_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~wHeld_r & ~s_axi_bvalid;
  assign doWrite  = awHeld_r & wHeld_r & ~s_axi_bvalid;
  assign wByte    = wData_r[7:0];
  assign wrHit    = doWrite & wStrb_r[0];
  assign pinToggleWr = wrHit & (awAddr_r == `PPM_OFF_PIN);

  always @*
  begin
    out_nxt = out_r;
    if (wrHit && awAddr_r == `PPM_OFF_OUT)
      out_nxt = wByte;
    if (pinToggleWr)
      out_nxt = out_nxt ^ wByte;
    out_nxt = out_nxt ^ toggleOverrideEn;
  end

  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      awHeld_r     <= 1'b0;
      wHeld_r      <= 1'b0;
      awAddr_r     <= 8'h00;
      wData_r      <= 32'h0000_0000;
      wStrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PPM_RESP_OKAY;
      dir_r        <= `PPM_RST_BYTE;
      out_r        <= `PPM_RST_BYTE;
      ctrl_r       <= `PPM_RST_CTRL;
      alt_r        <= `PPM_RST_CTRL;
      imask_r      <= 2'b00;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      out_r <= out_nxt;
      if (doWrite)
      begin
        awHeld_r     <= 1'b0;
        wHeld_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `PPM_RESP_OKAY;
        case ({awAddr_r[7:2], 2'b00})
          `PPM_OFF_DIR:   if (wStrb_r[0]) dir_r <= wByte;
          `PPM_OFF_OUT:   ;
          `PPM_OFF_PIN:   ;
          `PPM_OFF_CTRL:  if (wStrb_r[0]) ctrl_r <= wByte[2:0];
          `PPM_OFF_ALT:   if (wStrb_r[0]) alt_r <= wByte[2:0];
          `PPM_OFF_ISTAT: ;
          `PPM_OFF_IMASK: if (wStrb_r[0]) imask_r <= wByte[1:0];
          default:        s_axi_bresp <= `PPM_RESP_SLVERR;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // events: clamp-made edge on the interrupt pin, pin change
  // ---------------------------------------------------------------------------
  // a high pin with its interrupt off falls under the clamp; wake restores it
  assign extWake = sleepPrev_r & ~sleepClamp & extPend_r;
  assign evSet   = {(|(inSync ^ altPrev_r)) & alt_r[`PPM_ALT_PCIE], extWake};

  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sleepPrev_r <= 1'b0;
      extPend_r   <= 1'b0;
      altPrev_r   <= `PPM_RST_BYTE;
      istat_r     <= 2'b00;
    end
    else
    begin
      sleepPrev_r <= sleepClamp;
      altPrev_r   <= inSync;
      // synced copy lags the clamp, so it still shows the pre-sleep level
      if (sleepClamp && !sleepPrev_r)
        extPend_r <= ~extEn & inSync[`PPM_EXT_PIN];
      else if (!sleepClamp)
        extPend_r <= 1'b0;
      // set wins over a same-cycle clear
      if (wrHit && awAddr_r == `PPM_OFF_ISTAT)
        istat_r <= (istat_r & ~wByte[1:0]) | evSet;
      else
        istat_r <= istat_r | evSet;
    end
  end

  assign irq = |(istat_r & imask_r);

  // ---------------------------------------------------------------------------
  // axi4-lite read path
  // ---------------------------------------------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `PPM_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `PPM_RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        `PPM_OFF_DIR:   s_axi_rdata <= {24'h00_0000, dir_r};
        `PPM_OFF_OUT:   s_axi_rdata <= {24'h00_0000, out_r};
        `PPM_OFF_PIN:   s_axi_rdata <= {24'h00_0000, pin_r};
        `PPM_OFF_CTRL:  s_axi_rdata <= {29'h0000_0000, ctrl_r};
        `PPM_OFF_ALT:   s_axi_rdata <= {29'h0000_0000, alt_r};
        `PPM_OFF_ISTAT: s_axi_rdata <= {30'h0000_0000, istat_r};
        `PPM_OFF_IMASK: s_axi_rdata <= {30'h0000_0000, imask_r};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `PPM_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule
`default_nettype wire

// ==== testbench/ppm_periph_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// timer and spi stand-ins
// ----------------------------------------
module ppm_periph_model
(
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic [3:0] timerRun,
  output var  logic [3:0] cmpOut,
  output var  logic [3:0] cmpEn,
  output var  logic [2:0] spiOut
);
  // flips every cycle even while disabled, so a stale value never matches
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cmpOut <= 4'hA;
      cmpEn  <= 4'h0;
      spiOut <= 3'h5;
    end
    else
    begin
      cmpOut <= ~cmpOut;
      cmpEn  <= timerRun;
      spiOut <= ~spiOut;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/ppm_port_mux_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// port-level checks
// ----------------------------------------
module ppm_port_mux_asserts
(
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic [7:0] padIn,
  input wire logic [7:0] padOut,
  input wire logic [7:0] padOe,
  input wire logic [7:0] pullupOn,
  input wire logic       timer2CompareAOut,
  input wire logic       timer2CompareAEn,
  input wire logic [7:0] toggleOverrideEn,
  input wire logic [7:0] altDigitalInput,
  input wire logic       spiMasterIn,
  input wire logic       spiSlaveIn,
  input wire logic       spiSckIn,
  input wire logic       spiSelectIn,
  input wire logic       irq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  a_reset_tristate: assert property (@(posedge sys_clk)
    disable iff (1'b0) !rstn |-> padOe == 8'h00 && pullupOn == 8'h00)
    else $error("pin live at reset");
  a_value_override: assert property (padOe[7] && timer2CompareAEn |->
    padOut[7] == timer2CompareAOut) else $error("override not driven");
  a_pullup_output: assert property (
    (pullupOn[7:4] & padOe[7:4]) == 4'h0) else $error("pull-up on output");
  a_alt_gated: assert property (
    (altDigitalInput & ~padIn) == 8'h00) else $error("input not from pad");
  a_spi_input_map: assert property (
    {spiMasterIn, spiSlaveIn, spiSckIn, spiSelectIn} == altDigitalInput[3:0])
    else $error("spi input map wrong");
  a_toggle_flips: assert property (
    toggleOverrideEn[7] && padOe[7] && !timer2CompareAEn |=>
    padOut[7] != $past(padOut[7])) else $error("toggle lost");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  a_write_done: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid) else $error("write answer repeated");
  c_override: cover property (padOe[7] && timer2CompareAEn);
  c_toggle: cover property (toggleOverrideEn[7] && padOe[7]);
  c_irq: cover property (irq);
endmodule
bind ppm_port_mux ppm_port_mux_asserts u_chk (.*);
`default_nettype wire

// ==== testbench/ppm_port_mux_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ppm_defs.vh"
module ppm_port_mux_tb_top;
  logic        sys_clk, rstn = 1'b0, irq;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rdq;
  logic [3:0]  s_axi_wstrb = 4'hF, timerRun = 4'h0, cmpOut, cmpEn;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, spiMasterIn, spiSlaveIn, spiSckIn, spiSelectIn;
  logic [7:0]  padIn = 8'h00, toggleOverrideEn = 8'h00;
  logic [7:0]  padOut, padOe, pullupOn, altDigitalInput, pinChangeSrc;
  logic [2:0]  spiOut;
  int          nErrors = 0, totalChecks = 0;
  // ----------------------------------------
  // design, peripherals, clock
  // ----------------------------------------
  ppm_port_mux uut
  (
    .timer2CompareAOut (cmpOut[3]),
    .timer2CompareAEn  (cmpEn[3]),
    .timer1CompareBOut (cmpOut[2]),
    .timer1CompareBEn  (cmpEn[2]),
    .timer1CompareAOut (cmpOut[1]),
    .timer1CompareAEn  (cmpEn[1]),
    .timer0CompareAOut (cmpOut[0]),
    .timer0CompareAEn  (cmpEn[0]),
    .spiSlaveOut       (spiOut[2]),
    .spiMasterOut      (spiOut[1]),
    .spiSckOut         (spiOut[0]),
    .*
  );
  ppm_periph_model peri (.*);
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      totalChecks++;
      if (got !== exp)
      begin
        nErrors++;
        $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task automatic finish_test;
    begin
      $display("checks %0d errors %0d", totalChecks, nErrors);
      if (nErrors == 0 && totalChecks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // ready is sampled on the falling edge, where it has settled
  task automatic bus(input logic isWr, input logic [7:0] a,
                     input logic [31:0] d);
    logic pa, pw, ta, tw, done;
    int   n;
    begin
      @(posedge sys_clk);
      pa = 1'b1;
      pw = isWr;
      done = 1'b0;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= isWr;
      s_axi_wvalid <= isWr;
      s_axi_bready <= isWr;
      s_axi_arvalid <= !isWr;
      s_axi_rready <= !isWr;
      while (!done && n < 40)
      begin
        @(negedge sys_clk);
        ta = pa & (isWr ? s_axi_awready : s_axi_arready);
        tw = pw & s_axi_wready;
        done = (isWr ? s_axi_bvalid : s_axi_rvalid) === 1'b1;
        rdq = s_axi_rdata;
        rsp = isWr ? s_axi_bresp : s_axi_rresp;
        @(posedge sys_clk);
        n++;
        if (ta)
        begin
          pa = 1'b0;
          s_axi_awvalid <= 1'b0;
          s_axi_arvalid <= 1'b0;
        end
        if (tw)
        begin
          pw = 1'b0;
          s_axi_wvalid <= 1'b0;
        end
      end
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
      if (!done)
      begin
        nErrors++;
        $display("ERROR %0t bus timeout", $time);
        finish_test;
      end
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    begin
      bus(1'b0, a, 32'h0000_0000);
      chk(rdq, e);
    end
  endtask
  task automatic clamp_case(input logic [7:0] c, al, e);
    begin
      wr_reg(`PPM_OFF_CTRL, {24'h00_0000, c});
      wr_reg(`PPM_OFF_ALT, {24'h00_0000, al});
      @(negedge sys_clk);
      chk(altDigitalInput, e);
      chk(pinChangeSrc, e);
    end
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    repeat (10) @(posedge sys_clk);
    chk(padOe, 8'h00);
    chk(pullupOn, 8'h00);
    rstn <= 1'b1;
    wr_reg(`PPM_OFF_DIR, 32'h0000_000F);
    wr_reg(`PPM_OFF_OUT, 32'h0000_00F3);
    @(negedge sys_clk);
    chk(padOe, 8'h0F);
    chk(padOut & 8'h0F, 8'h03);
    chk(pullupOn, 8'hF0);
    wr_reg(`PPM_OFF_CTRL, 32'h0000_0001);
    @(negedge sys_clk);
    chk(pullupOn, 8'h00);
    rd_chk(`PPM_OFF_DIR, 32'h0000_000F);
    wr_reg(`PPM_OFF_PIN, 32'h0000_0081);
    rd_chk(`PPM_OFF_OUT, 32'h0000_0072);
    wr_reg(`PPM_OFF_DIR, 32'h0000_00F0);
    wr_reg(`PPM_OFF_OUT, 32'h0000_0050);
    @(posedge sys_clk);
    toggleOverrideEn <= 8'h80;
    @(posedge sys_clk);
    toggleOverrideEn <= 8'h00;
    rd_chk(`PPM_OFF_OUT, 32'h0000_00D0);
    timerRun <= 4'h9;
    repeat (2) @(posedge sys_clk);
    repeat (3)
    begin
      @(negedge sys_clk);
      chk(padOut[7:4], {cmpOut[3], 2'h2, cmpOut[0]});
    end
    @(posedge sys_clk);
    timerRun <= 4'h0;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(padOut[7:4], 4'hD);
    @(posedge sys_clk);
    padIn <= 8'hA5;
    rd_chk(`PPM_OFF_PIN, 32'h0000_00A5);
    @(posedge sys_clk);
    padIn <= 8'hFF;
    clamp_case(8'h00, 8'h00, 8'hFF);
    clamp_case(8'h02, 8'h00, 8'h00);
    clamp_case(8'h06, 8'h00, 8'h02);
    clamp_case(8'h02, 8'h04, 8'hFF);
    clamp_case(8'h00, 8'h00, 8'hFF);
    wr_reg(`PPM_OFF_ISTAT, 32'h0000_0003);
    rd_chk(`PPM_OFF_ISTAT, 32'h0000_0000);
    wr_reg(`PPM_OFF_IMASK, 32'h0000_0001);
    wr_reg(`PPM_OFF_CTRL, 32'h0000_0002);
    wr_reg(`PPM_OFF_CTRL, 32'h0000_0000);
    rd_chk(`PPM_OFF_ISTAT, 32'h0000_0001);
    @(negedge sys_clk);
    chk(irq, 1'b1);
    wr_reg(`PPM_OFF_IMASK, 32'h0000_0000);
    @(negedge sys_clk);
    chk(irq, 1'b0);
    wr_reg(`PPM_OFF_IMASK, 32'h0000_0001);
    wr_reg(`PPM_OFF_ISTAT, 32'h0000_0001);
    @(negedge sys_clk);
    chk(irq, 1'b0);
    rd_chk(`PPM_OFF_ISTAT, 32'h0000_0000);
    bus(1'b1, 8'h1C, 32'h0000_00FF);
    chk(rsp, `PPM_RESP_SLVERR);
    bus(1'b0, 8'h1C, 32'h0000_0000);
    chk(rsp, `PPM_RESP_SLVERR);
    chk(rdq, 32'h0000_0000);
    wr_reg(`PPM_OFF_DIR, 32'h0000_000F);
    wr_reg(`PPM_OFF_OUT, 32'h0000_00F0);
    wr_reg(`PPM_OFF_ALT, 32'h0000_0003);
    @(negedge sys_clk);
    chk(padOe, 8'h00);
    chk(padOut[3:1], spiOut);
    wr_reg(`PPM_OFF_ALT, 32'h0000_0000);
    @(negedge sys_clk);
    chk(pullupOn, 8'hF0);
    chk(padOe, 8'h0F);
    // tri-state must follow reset before any clock edge
    @(posedge sys_clk);
    rstn <= 1'b0;
    #2;
    chk(padOe, 8'h00);
    chk(pullupOn, 8'h00);
    @(posedge sys_clk);
    rstn <= 1'b1;
    rd_chk(`PPM_OFF_OUT, 32'h0000_0000);
    finish_test;
  end
endmodule
`default_nettype wire
